// File: design/pcsr_regs.sv
// Socket status, change flags and power control registers on Wishbone
// Notes on behaviour
// - Status bits 7 and 6 show voltage sense 2 and 1; high means present.
// - Status bit 5 shows ready/busy, or card interrupt pin for I/O cards.
// - Status bit 4 shows write protect; meaningless for I/O cards.
// - Status bits 3 and 2 show the two card detect inputs.
// - Status bits 1 and 0 show battery detect: 11 good, 01 warn.
// - Change bit 7 software card detect, bit 6 hardware card detect.
// - Change bit 5 set by pulse-mode card interrupt, else reads 0.
// - Change bit 4 is one when ring enable low and ring input low.
// - Change bits 3 ring, 2 ready, 1 and 0 battery warning.
// - Change sources raise interrupt only when enabled; bits 2 to 0 share one enable, any of config bits 3 to 0.
// - Default mode clears change register when software reads it.
// - Write-back mode clears change register by a software write.
// - Write-back acknowledge writes 1 to the flagged change bit.
// - Writing 1 to power bit 7 resets the whole adapter.
// - Power bit 6 low tristates card strobes, enables and reset.
// - Power bit 5 high, bit 4 set: either card detect input high drives both supply enables 0.
// - Power bit 4 low drives both supply enables 1.
// - Power bits 3 and 2 drive programming enables b and a.
// - Power bit 1 high: voltage sense 1 low picks 5V, high 3V.
// - Bit 1 low, bit 4 set: bit 0 picks 5V when 0, 3V when 1.
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/10ps
`include "pcsr_map.svh"
module pcsr_regs
  import pcsr_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [4:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire pcsr_pins_t  PINS,
  output pcsr_power_t      POWER,
  output logic             CARD_OUT_EN,
  output logic             CARD_IRQ,
  output logic             CARD_RESET_DRIVE,
  output logic             HOST_ADAPTER_RESET
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  power_ff;
  logic [7:0]  global_ff;
  logic [7:0]  irqcfg_ff;
  logic [7:0]  event_ff;
  logic [7:0]  nxt_event;
  pcsr_pins_t  pins_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        srst_ff;
  logic        rst_n;
  logic        req;
  logic        wr_req;
  logic        rd_req;
  logic        io_card;
  logic        ring_en;
  logic [7:0]  status;
  logic [7:0]  rise_ev;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  // Soft reset acts one cycle after the write, on all but srst_ff, pins_ff and HOST_ADAPTER_RESET
  assign rst_n   = RESETN & ~srst_ff;
  assign req     = CYC_I & STB_I & ~ack_ff;
  assign wr_req  = req & WE_I & SEL_I[0];
  assign rd_req  = req & ~WE_I;
  assign io_card = global_ff[`PCSR_GL_IOCARD];
  assign ring_en = irqcfg_ff[`PCSR_GL_RINGEN];

  ////////////////////////////////////////////////////////////////////////
  // live pins
  assign status = PINS;

  // Loaded in reset too, so no false edge once reset ends
  always_ff @(posedge CLK_SYS)
  begin
    pins_ff <= PINS;
  end

  ////////////////////////////////////////////////////////////////////////
  // soft reset pulse
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      srst_ff <= 1'b0;
    else
      srst_ff <= wr_req & hit(ADR_I, {1'b0, `PCSR_ADR_POWER})
                 & DAT_I[`PCSR_PW_SRST] & ~srst_ff;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!rst_n)
      power_ff <= `PCSR_POWER_RST;
    else if (wr_req && hit(ADR_I, {1'b0, `PCSR_ADR_POWER}))
      power_ff <= {1'b0, DAT_I[6:0]};
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!rst_n)
      global_ff <= `PCSR_GLOBAL_RST;
    else if (wr_req && hit(ADR_I, {1'b0, `PCSR_ADR_GLOBAL}))
      global_ff <= DAT_I[7:0];
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!rst_n)
      irqcfg_ff <= `PCSR_IRQCFG_RST;
    else if (wr_req && hit(ADR_I, `PCSR_ADR_CFG))
      irqcfg_ff <= DAT_I[7:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // edge events per source
  always_comb
  begin
    rise_ev    = '0;
    rise_ev[7] = wr_req & hit(ADR_I, {1'b0, `PCSR_ADR_GLOBAL})
                 & DAT_I[`PCSR_GL_SWCD];
    rise_ev[6] = (pins_ff.cd1 ^ PINS.cd1) | (pins_ff.cd2 ^ PINS.cd2);
    // pulse mode edge, falling (10) or rising (11)
    rise_ev[5] = io_card & irqcfg_ff[5] &
                 (irqcfg_ff[4] ? (~pins_ff.rdy_ireq & PINS.rdy_ireq)
                               : (pins_ff.rdy_ireq & ~PINS.rdy_ireq));
    rise_ev[3] = io_card & (pins_ff.bvd1_stschg ^ PINS.bvd1_stschg);
    rise_ev[2] = ~io_card & (pins_ff.rdy_ireq ^ PINS.rdy_ireq);
    rise_ev[1] = ~io_card & ~PINS.bvd2_spkr & pins_ff.bvd2_spkr;
    rise_ev[0] = ~io_card & ~PINS.bvd1_stschg & pins_ff.bvd1_stschg;
  end

  always_comb
  begin
    nxt_event = event_ff;
    // acknowledge method from the write-back option
    if (global_ff[`PCSR_GL_WBACK])
    begin
      if (wr_req && hit(ADR_I, {1'b0, `PCSR_ADR_EVENT}))
        nxt_event = event_ff & ~DAT_I[7:0];
    end
    else if (rd_req && hit(ADR_I, {1'b0, `PCSR_ADR_EVENT}))
      nxt_event = '0;
    // Set wins over a same-cycle clear
    nxt_event = nxt_event | rise_ev;
    // bit 4 is a live level, not a latch
    nxt_event[4] = ~ring_en & ~PINS.bvd1_stschg;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!rst_n)
      event_ff <= '0;
    else
      event_ff <= nxt_event;
  end

  ////////////////////////////////////////////////////////////////////////
  // enable gating, cfg 7 ring, 6 detect, 5:4 card irq
  always_ff @(posedge CLK_SYS)
  begin
    if (!rst_n)
      CARD_IRQ <= 1'b0;
    else
      CARD_IRQ <= (|event_ff[7:6] & irqcfg_ff[6])
                | (event_ff[5] & irqcfg_ff[5])
                | (irqcfg_ff[5:4] == 2'b01 & io_card & ~PINS.rdy_ireq)
                | (event_ff[3] & irqcfg_ff[7])
                | (|event_ff[2:0] & |irqcfg_ff[3:0]);
  end

  ////////////////////////////////////////////////////////////////////////
  // power outputs
  always_ff @(posedge CLK_SYS)
  begin
    if (!rst_n)
    begin
      POWER              <= '0;
      CARD_OUT_EN        <= 1'b0;
      CARD_RESET_DRIVE   <= 1'b0;
    end
    else
    begin
      CARD_OUT_EN <= power_ff[`PCSR_PW_OE];
      CARD_RESET_DRIVE <= power_ff[`PCSR_PW_OE] & global_ff[5];
      POWER.prog_supply_enable_b <= power_ff[3];
      POWER.prog_supply_enable_a <= power_ff[2];
      if (!power_ff[`PCSR_PW_SOCK])
      begin
        POWER.supply_5v_enable <= 1'b1;
        POWER.supply_3v_enable <= 1'b1;
      end
      else if (power_ff[`PCSR_PW_AUTO] && (PINS.cd1 | PINS.cd2))
      begin
        POWER.supply_5v_enable <= 1'b0;
        POWER.supply_3v_enable <= 1'b0;
      end
      else if (power_ff[`PCSR_PW_DIRECT])
      begin
        POWER.supply_5v_enable <= ~PINS.vs1;
        POWER.supply_3v_enable <= PINS.vs1;
      end
      else
      begin
        POWER.supply_5v_enable <= ~power_ff[`PCSR_PW_VSEL];
        POWER.supply_3v_enable <= power_ff[`PCSR_PW_VSEL];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // adapter reset pulse
  // Own reset: the soft reset must not swallow its own pulse
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
      HOST_ADAPTER_RESET <= 1'b0;
    else
      HOST_ADAPTER_RESET <= srst_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after request, unmapped reads zero
  always_ff @(posedge CLK_SYS)
  begin
    if (!rst_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= req;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!rst_n)
      dat_ff <= '0;
    else if (rd_req)
      unique case (ADR_I)
        {1'b0, `PCSR_ADR_STATUS}: dat_ff <= {24'h000000, status};
        {1'b0, `PCSR_ADR_EVENT}:  dat_ff <= {24'h000000, event_ff};
        {1'b0, `PCSR_ADR_POWER}:  dat_ff <= {24'h000000, power_ff};
        {1'b0, `PCSR_ADR_GLOBAL}: dat_ff <= {24'h000000, global_ff};
        `PCSR_ADR_CFG:            dat_ff <= {24'h000000, irqcfg_ff};
        default:                  dat_ff <= '0;
      endcase
  end

  assign DAT_O = dat_ff;
  assign ACK_O = ack_ff;

  ////////////////////////////////////////////////////////////////////////
  // both supplies on
  supply_both_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    !power_ff[4] |=> POWER.supply_5v_enable && POWER.supply_3v_enable)
    else $error("supplies not both on");

  prog_supply_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    ##1 {POWER.prog_supply_enable_b, POWER.prog_supply_enable_a}
        == $past(power_ff[3:2]))
    else $error("prog supply wrong");

  out_enable_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    !power_ff[6] |=> !CARD_OUT_EN)
    else $error("outputs not tristated");

  out_driven_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    power_ff[6] |=> CARD_OUT_EN)
    else $error("outputs not driven");

  ring_level_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    ##1 event_ff[4] == $past(~ring_en & ~PINS.bvd1_stschg))
    else $error("ring level bit wrong");

  read_clear_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    rd_req && ADR_I == 5'h04 && !global_ff[1] && rise_ev == 8'h00
    |=> event_ff[7:5] == 3'h0)
    else $error("read did not clear");

  wb_keep_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    rd_req && global_ff[1] && event_ff[6] |=> event_ff[6])
    else $error("read cleared in write-back mode");

  wb_clear_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    wr_req && ADR_I == 5'h04 && global_ff[1] && DAT_I[6] && !rise_ev[6]
    |=> !event_ff[6])
    else $error("write-back did not clear");

  detect_set_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    rise_ev[6] |=> event_ff[6])
    else $error("detect change not latched");

  detect_hold_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    event_ff[6] && !rd_req && !wr_req |=> event_ff[6])
    else $error("detect flag lost");

  vsel_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    power_ff[4] && !power_ff[5] && !power_ff[1]
    |=> POWER.supply_3v_enable == $past(power_ff[0]))
    else $error("voltage select wrong");

  sense_pick_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    power_ff[4] && !power_ff[5] && power_ff[1]
    |=> POWER.supply_3v_enable == $past(PINS.vs1)
        && POWER.supply_5v_enable == !$past(PINS.vs1))
    else $error("sense select wrong");

  auto_off_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    power_ff[4] && power_ff[5] && (PINS.cd1 || PINS.cd2)
    |=> !POWER.supply_5v_enable && !POWER.supply_3v_enable)
    else $error("auto power not off");

  status_live_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    rd_req && ADR_I == 5'h00 |=> DAT_O[7:0] == $past(PINS))
    else $error("status read wrong");

  sw_detect_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    wr_req && ADR_I == 5'h0c && DAT_I[4] |=> event_ff[7])
    else $error("software detect not set");

  pulse_irq_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    io_card && irqcfg_ff[5:4] == 2'b10 && pins_ff.rdy_ireq
    && !PINS.rdy_ireq |=> event_ff[5])
    else $error("pulse request not set");

  ready_change_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    !io_card && pins_ff.rdy_ireq != PINS.rdy_ireq |=> event_ff[2])
    else $error("ready change not set");

  irq_mask_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    irqcfg_ff == 8'h00 |=> !CARD_IRQ)
    else $error("masked interrupt raised");

  soft_reset_a: assert property (
    @(posedge CLK_SYS) disable iff (!RESETN)
    srst_ff |=> HOST_ADAPTER_RESET)
    else $error("adapter reset not pulsed");

  // Upper read lanes zero
  upper_zero_a: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    ACK_O |-> DAT_O[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
endmodule

// File: design/pcsr_map.svh
// Register offsets, field positions and reset values of the socket block
`ifndef PCSR_MAP_SVH
`define PCSR_MAP_SVH
`define PCSR_ADR_STATUS   4'h0
`define PCSR_ADR_EVENT    4'h4
`define PCSR_ADR_POWER    4'h8
`define PCSR_ADR_GLOBAL   4'hc
`define PCSR_ADR_IRQCFG   4'h0
`define PCSR_POWER_RST    8'h00
`define PCSR_GLOBAL_RST   8'h00
`define PCSR_IRQCFG_RST   8'h00
`define PCSR_ADR_CFG      5'h10
`define PCSR_PW_SRST      7
`define PCSR_PW_OE        6
`define PCSR_PW_AUTO      5
`define PCSR_PW_SOCK      4
`define PCSR_PW_DIRECT    1
`define PCSR_PW_VSEL      0
`define PCSR_GL_SWCD      4
`define PCSR_GL_IOCARD    3
`define PCSR_GL_WBACK     1
`define PCSR_GL_RINGEN    7
`endif

// File: design/pcsr_pkg.sv
// Types shared by the socket status and power register block
package pcsr_pkg;
  typedef struct packed {
    logic       vs2;
    logic       vs1;
    logic       rdy_ireq;
    logic       wp;
    logic       cd2;
    logic       cd1;
    logic       bvd2_spkr;
    logic       bvd1_stschg;
  } pcsr_pins_t;

  typedef struct packed {
    logic       supply_5v_enable;
    logic       supply_3v_enable;
    logic       prog_supply_enable_b;
    logic       prog_supply_enable_a;
  } pcsr_power_t;
endpackage

// File: verification/pcsr_card_model.sv
// Behavioural PC card that drives the socket pins for the bench
`timescale 1ns/10ps
module pcsr_card_model
  import pcsr_pkg::*;
(
  input  wire logic       CLK_SYS,
  input  wire pcsr_pins_t want,
  input  wire logic [3:0] lag,
  input  wire logic       card_reset_drive,
  output pcsr_pins_t      pins
);
  //////////////////////////////////////////////////////////////////////
  pcsr_pins_t cur_ff;
  logic [3:0] cnt_ff;

  // Slow cards settle their pins some cycles late
  always_ff @(posedge CLK_SYS)
  begin
    if (want != cur_ff && cnt_ff < lag)
      cnt_ff <= cnt_ff + 4'h1;
    else
    begin
      cur_ff <= want;
      cnt_ff <= 4'h0;
    end
  end

  // A card held in reset reports busy
  always_comb
  begin
    pins = cur_ff;
    if (card_reset_drive)
      pins.rdy_ireq = 1'b0;
  end
endmodule

// File: verification/pcsr_regs_tb.sv
// Self-checking bench for the socket status and power registers
`timescale 1ns/10ps
module pcsr_regs_tb
  import pcsr_pkg::*;
  ;
  typedef struct {logic [7:0] v; logic [7:0] m;} pcsr_note_t;
  localparam logic [4:0] a_st = 5'h00, a_ev = 5'h04, a_pw = 5'h08;
  localparam logic [4:0] a_gl = 5'h0c, a_cf = 5'h10;
  logic        clk, rstn, cyc, stb, we, ack, oen, irq, crd, har, srst;
  logic [4:0]  adr;
  logic [31:0] dw, dr;
  logic [7:0]  p;
  logic [3:0]  lag;
  logic [1:0]  sup [2];
  pcsr_pins_t  want, pins;
  pcsr_power_t pw;
  pcsr_note_t  nq [$];
  pcsr_note_t  n;
  int          fail_count = 0;
  int          cmp_count = 0;

  pcsr_regs u_pcsr_regs (.CLK_SYS(clk), .RESETN(rstn), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'h1), .DAT_I(dw),
    .DAT_O(dr), .ACK_O(ack), .PINS(pins), .POWER(pw), .CARD_OUT_EN(oen),
    .CARD_IRQ(irq), .CARD_RESET_DRIVE(crd), .HOST_ADAPTER_RESET(har));
  pcsr_card_model u_pcsr_card_model (.CLK_SYS(clk), .want(want),
    .lag(lag), .card_reset_drive(crd), .pins(pins));

  //////////////////////////////////////////////////////////////////////
  task automatic ck(string s, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  // Lost ack on soft reset is cut short and the run goes on
  task automatic wb(logic w, logic [4:0] a, logic [7:0] d, logic [7:0] m);
    int k;
    k = 0;
    if (!w)
      nq.push_back('{d, m});
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= {24'h0, d};
    do
      @(posedge clk);
    while (ack !== 1'b1 && ++k < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic pn(logic [7:0] v);
    @(posedge clk);
    want <= v;
    repeat (10) @(posedge clk);
  endtask

  task automatic st();
    repeat (4) @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
  begin
    if (har === 1'b1)
      srst <= 1'b1;
    if (ack === 1'b1 && we === 1'b0)
    begin
      n = nq.size() > 0 ? nq.pop_front() : '{8'h00, 8'h00};
      ck("read data", n.v & n.m, dr[7:0] & n.m);
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #100000;
    fail_count++;
    wrap_up();
  end

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    {rstn, cyc, stb, we, srst} = 5'h0;
    adr = 5'h00;
    dw = 32'h0;
    want = 8'h23;
    lag = 4'h0;
    void'($urandom(32'h7ed6c3df));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      p = 8'($urandom);
      lag <= i[3:0];
      wb(1'b1, a_gl, {4'h0, i[0], 3'h0}, 8'h00);
      pn(p);
      wb(1'b0, a_st, p, 8'hff);
    end
    $display("status test done");
    pn(8'h23);
    wb(1'b1, a_pw, 8'h40, 8'h00);
    st();
    ck("output enable", 8'h01, {7'h0, oen});
    ck("supplies", 8'h03, {6'h0, pw[3:2]});
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, a_pw, {4'h1, i[1:0], 1'b0, i[0]}, 8'h00);
      st();
      ck("prog", {6'h0, i[1:0]}, {6'h0, pw[1:0]});
      ck("output off", 8'h00, {7'h0, oen});
      sup[i[0]] = pw[3:2];
    end
    ck("voltage select 0", 8'h02, {6'h0, sup[0]});
    ck("voltage select 1", 8'h01, {6'h0, sup[1]});
    wb(1'b1, a_pw, 8'h12, 8'h00);
    st();
    ck("sense low", {6'h0, sup[0]}, {6'h0, pw[3:2]});
    pn(8'h63);
    ck("sense high", {6'h0, sup[1]}, {6'h0, pw[3:2]});
    wb(1'b1, a_pw, 8'h30, 8'h00);
    pn(8'h2f);
    ck("auto off", 8'h00, {6'h0, pw[3:2]});
    pn(8'h23);
    ck("auto on", {6'h0, sup[0]}, {6'h0, pw[3:2]});
    wb(1'b1, a_pw, 8'h80, 8'h00);
    st();
    ck("soft reset", 8'h01, {7'h0, srst});
    wb(1'b0, a_pw, 8'h00, 8'hff);
    $display("power test done");
    wb(1'b0, a_ev, 8'h00, 8'h00);
    pn(8'h27);
    wb(1'b0, a_ev, 8'h40, 8'hff);
    wb(1'b0, a_ev, 8'h00, 8'hff);
    wb(1'b1, a_gl, 8'h02, 8'h00);
    pn(8'h23);
    wb(1'b0, a_ev, 8'h40, 8'hff);
    wb(1'b0, a_ev, 8'h40, 8'hff);
    wb(1'b1, a_ev, 8'h40, 8'h00);
    wb(1'b0, a_ev, 8'h00, 8'hff);
    wb(1'b1, a_cf, 8'h40, 8'h00);
    wb(1'b1, a_gl, 8'h12, 8'h00);
    wb(1'b1, a_gl, 8'h02, 8'h00);
    st();
    ck("irq raised", 8'h01, {7'h0, irq});
    wb(1'b0, a_ev, 8'h80, 8'hff);
    wb(1'b1, a_ev, 8'h80, 8'h00);
    st();
    ck("irq cleared", 8'h00, {7'h0, irq});
    wb(1'b1, a_cf, 8'h00, 8'h00);
    pn(8'h27);
    ck("irq masked", 8'h00, {7'h0, irq});
    wb(1'b0, a_ev, 8'h40, 8'hff);
    wb(1'b1, a_ev, 8'hff, 8'h00);
    pn(8'h26);
    wb(1'b0, a_ev, 8'h10, 8'h10);
    wb(1'b1, a_cf, 8'h80, 8'h00);
    wb(1'b0, a_ev, 8'h00, 8'h10);
    wb(1'b1, a_cf, 8'h20, 8'h00);
    wb(1'b1, a_gl, 8'h0a, 8'h00);
    pn(8'h06);
    wb(1'b0, a_ev, 8'h20, 8'h20);
    wb(1'b1, a_ev, 8'hff, 8'h00);
    wb(1'b0, a_ev, 8'h00, 8'h20);
    $display("event test done");
    st();
    wrap_up();
  end
endmodule
